// >>> bench/sbsa_eeprom_model.sv
// sbsa_eeprom_model: behavioural two-wire eeprom slave for the bench
module sbsa_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // wire levels and pull-down enables
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_oe,
  output logic            sda_oe,
  // bench controls: 3 in nack_phase means acknowledge all
  input  wire logic       quick_mode,
  input  wire logic [1:0] nack_phase,
  input  wire logic       stretch
);
  logic [7:0] mem [256];
  logic [7:0] ptr, sh, tx;
  logic [3:0] cnt;
  logic [1:0] phase;
  logic [4:0] str_cnt;
  logic       rd_mode, rd_pend, acked, got_nack, scl_q, sda_q;
  wire        ack_now = !rd_mode && nack_phase != phase &&
                        (phase != 2'h0 || sh[7:1] == DEV_ADDR);
  assign scl_oe = str_cnt != 5'h0;
  initial for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {scl_q, sda_q} <= 2'h3;
      {rd_mode, rd_pend, acked, got_nack, sda_oe} <= 5'h0;
      {cnt, phase, str_cnt, ptr} <= 19'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (str_cnt != 5'h0) str_cnt <= str_cnt - 5'h1;
      if (scl && scl_q && sda_q && !sda) begin
        // the clock fall that closes a start is not a data bit
        {cnt, phase, rd_mode, rd_pend, sda_oe} <= 9'h1E0;
      end else if (scl && scl_q && !sda_q && sda) begin
        {cnt, phase, rd_mode, sda_oe} <= 8'h0;
      end else if (scl && !scl_q) begin
        if (cnt < 4'h8) sh <= {sh[6:0], sda};
        else if (rd_mode) got_nack <= sda;
      end else if (scl_q && !scl) begin
        // slow answer: hold the clock low after every falling edge
        if (stretch) str_cnt <= 5'h14;
        if (cnt == 4'hF) cnt <= 4'h0;
        else if (cnt < 4'h7) begin
          cnt <= cnt + 4'h1;
          if (rd_mode) begin
            tx <= {tx[6:0], 1'b1};
            sda_oe <= ~tx[6];
          end
        end else if (cnt == 4'h7) begin
          cnt <= 4'h8;
          sda_oe <= ack_now;
          acked <= ack_now;
          if (ack_now) begin
            if (phase == 2'h0) rd_pend <= sh[0];
            else if (phase == 2'h1) ptr <= sh;
            else begin
              mem[ptr] <= sh;
              ptr <= ptr + 8'h1;
            end
            phase <= (phase == 2'h2 || (phase == 2'h0 && quick_mode)) ?
                     2'h2 : phase + 2'h1;
          end
        end else begin
          cnt <= 4'h0;
          sda_oe <= 1'b0;
          if ((acked && rd_pend && !rd_mode) || (rd_mode && !got_nack)) begin
            rd_mode <= 1'b1;
            tx <= mem[ptr];
            sda_oe <= ~mem[ptr][7];
            ptr <= ptr + 8'h1;
          end else rd_mode <= 1'b0;
        end
      end
    end
  end
endmodule : sbsa_eeprom_model

// >>> bench/tb_top.sv
// tb_top: self-checking bench for the sbsa engine and an eeprom model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbsa_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid, stc, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
  logic        scl_o, sda_o;
  logic        dl_busy = 1'b0;
  logic        dl_err = 1'b0;
  logic        det = 1'b1;
  logic        m_quick = 1'b0;
  logic        m_slow = 1'b0;
  logic [1:0]  m_nack = 2'h3;
  int          failures = 0;
  int          n_checks = 0;
  // open-drain lines with pull-ups
  wire scl = ~(scl_oe | m_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe);

  sbsa_top #(.QTR_CYC(8)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .download_busy_flag(dl_busy), .download_error(dl_err),
    .interface_detected_flag(det), .serial_test_control(stc),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));

  sbsa_eeprom_model m (
    .sys_clk(sys_clk), .nrst(nrst), .scl(scl), .sda(sda),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .quick_mode(m_quick),
    .nack_phase(m_nack), .stretch(m_slow));

  always #4 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d);
    @(negedge sys_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(negedge sys_clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    check("read valid", {31'h0, cfg_rvalid}, 32'h1);
    d = cfg_rdata;
  endtask : cfg_read

  task automatic wait_idle(output logic [31:0] d);
    for (int i = 0; i < 3000; i++) begin
      cfg_read(SBSA_DATA_OFS, d);
      if (d[24+SBSA_CS_REQUEST_BUSY_FLAG] === 1'b0) return;
    end
    check("busy timeout", 32'h1, 32'h0);
    finish_test();
  endtask : wait_idle

  task automatic launch(input logic [7:0] w, dt, tg, input logic e,
                        output logic [31:0] d);
    cfg_read(SBSA_DATA_OFS, d);
    check("ready", {24'h0, d[31:24] & 8'h38}, 32'h08);
    cfg_write(SBSA_DATA_OFS, 4'h3, {16'h0, w, dt});
    cfg_write(SBSA_DATA_OFS, 4'h4, {8'h0, tg, 16'h0});
    cfg_read(SBSA_DATA_OFS, d);
    check("busy set", {31'h0, d[24+SBSA_CS_REQUEST_BUSY_FLAG]}, 32'h1);
    cfg_write(SBSA_DATA_OFS, 4'h4, {8'h0, ~tg, 16'h0});
    cfg_read(SBSA_DATA_OFS, d);
    check("target held", {24'h0, d[23:16]}, {24'h0, tg});
    wait_idle(d);
    check("bus idle", {30'h0, scl, sda}, 32'h3);
    check("error", {31'h0, d[24+SBSA_CS_ERR]}, {31'h0, e});
  endtask : launch

  task automatic t_reset;
    logic [31:0] d;
    check("pins", {27'h0, scl_o, sda_o, scl_oe, sda_oe, stc},
          32'h0);
    cfg_read(SBSA_DATA_OFS, d);
    check("reset window", d, 32'h0800_0000);
    cfg_read(8'hB4, d);
    check("unmapped read", d, 32'h0);
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] d;
    cfg_write(SBSA_DATA_OFS, 4'hB, 32'h8400_5AC3);
    cfg_read(SBSA_DATA_OFS, d);
    check("window rw", d, 32'h8C00_5AC3);
    check("test ctrl", {31'h0, stc}, 32'h1);
    dl_busy = 1'b1;
    dl_err = 1'b1;
    cfg_write(8'hB4, 4'hF, 32'hFFFF_FFFF);
    cfg_read(SBSA_DATA_OFS, d);
    check("status ro", d, 32'h9D00_5AC3);
    dl_busy = 1'b0;
    dl_err = 1'b0;
    cfg_write(SBSA_DATA_OFS, 4'h8, 32'h0);
    check("test ctrl off", {31'h0, stc}, 32'h0);
  endtask : t_regs

  task automatic t_write(input logic slow, input logic [7:0] w, dt);
    logic [31:0] d;
    m_slow = slow;
    launch(w, dt, 8'hA0, 1'b0, d);
    check("eeprom byte", {24'h0, m.mem[w]}, {24'h0, dt});
    m_slow = 1'b0;
  endtask : t_write

  task automatic t_read;
    logic [31:0] d;
    launch(8'h3C, 8'h00, 8'hA1, 1'b0, d);
    check("read byte", {24'h0, d[7:0]}, 32'hA5);
    check("master nack", {31'h0, m.got_nack}, 32'h1);
  endtask : t_read

  task automatic t_quick;
    logic [31:0] d;
    cfg_write(SBSA_DATA_OFS, 4'h8, 32'h8000_0000);
    m_quick = 1'b1;
    launch(8'h77, 8'h5A, 8'hA0, 1'b0, d);
    check("quick write", {24'h0, m.mem[8'h3D]}, 32'h5A);
    check("word ignored", {24'h0, m.mem[8'h77]}, 32'h88);
    launch(8'h77, 8'h00, 8'hA1, 1'b0, d);
    check("quick read", {24'h0, d[7:0]}, 32'hC1);
    cfg_write(SBSA_DATA_OFS, 4'h8, 32'h0);
    m_quick = 1'b0;
  endtask : t_quick

  task automatic t_nack;
    logic [31:0] d;
    // refusal of address, word and data byte in turn
    for (int p = 0; p < 3; p++) begin
      m_nack = p[1:0];
      launch(8'h10, 8'h11, 8'hA0, 1'b1, d);
    end
    // refused read address on the quick path
    m_nack = 2'h0;
    m_quick = 1'b1;
    cfg_write(SBSA_DATA_OFS, 4'h8, 32'h8000_0000);
    launch(8'h10, 8'h00, 8'hA1, 1'b1, d);
    m_quick = 1'b0;
    m_nack = 2'h3;
    cfg_write(SBSA_DATA_OFS, 4'h8, 32'h0200_0000);
    cfg_read(SBSA_DATA_OFS, d);
    check("error clear", {31'h0, d[24+SBSA_CS_ERR]}, 32'h0);
  endtask : t_nack

  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_write(1'b0, 8'h3C, 8'hA5);
    t_write(1'b1, 8'h40, 8'h96);
    t_read();
    t_quick();
    t_nack();
    finish_test();
  end
endmodule : tb_top

// >>> src/sbsa_bit_engine.sv
// sbsa_bit_engine: start, stop and byte transfers on the two-wire pins
module sbsa_bit_engine #(
  parameter int QTR_CYC = sbsa_pkg::SBSA_QTR_CYC
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // command side
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire sbsa_pkg::sbsa_cmd_t cmd,
  input  wire logic [7:0]          tx_byte,
  input  wire logic                tx_ack,
  output logic                     done,
  output logic [7:0]               rx_byte,
  output logic                     rx_ack,
  // open-drain pins
  input  wire logic                scl_i,
  output logic                     scl_o,
  output logic                     scl_oe,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe
);
  import sbsa_pkg::*;

  //----------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] filt;
  assign pin_in = {sda_i, scl_i};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] sh_r;
    logic       f_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        sh_r <= 3'h7;
        f_r  <= 1'b1;
      end else begin
        sh_r <= {sh_r[1:0], pin_in[g]};
        // a change counts once stages two and three agree
        if (sh_r[1] == sh_r[2]) f_r <= sh_r[2];
      end
    end
    assign filt[g] = f_r;
  end

  //----------------------------------------------------------------------
  // quarter-bit sequencer
  //----------------------------------------------------------------------
  logic        busy_r, done_r, smp_r, scl_oe_r, sda_oe_r;
  logic [1:0]  q_r;
  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic [8:0]  sh_r;
  sbsa_cmd_t   cmd_r;

  wire        is_data  = cmd_r == SBSA_CMD_WR || cmd_r == SBSA_CMD_RD;
  wire [3:0]  last_bit = is_data ? 4'h8 : 4'h0;
  wire        cnt_end  = cnt_r == 16'(QTR_CYC - 1);
  // a slave holding the clock low stretches the low phase
  wire        tick     = busy_r && cnt_end && !(q_r == 2'h1 && !filt[0]);
  wire        scl_rel  = is_data ? (q_r == 2'h1 || q_r == 2'h2)
                                 : (q_r != 2'h0);
  wire        sda_rel  = is_data ? sh_r[8]
                                 : ((cmd_r == SBSA_CMD_START) ^ q_r[1]);
  wire        accept   = cmd_valid && !busy_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      smp_r  <= 1'b1;
      q_r    <= 2'h0;
      cnt_r  <= 16'h0000;
      bit_r  <= 4'h0;
      sh_r   <= 9'h1FF;
      cmd_r  <= SBSA_CMD_STOP;
    end else begin
      done_r <= 1'b0;
      if (accept) begin
        busy_r <= 1'b1;
        cmd_r  <= cmd;
        q_r    <= 2'h0;
        cnt_r  <= 16'h0000;
        bit_r  <= 4'h0;
        sh_r   <= (cmd == SBSA_CMD_RD) ? {8'hFF, tx_ack} : {tx_byte, 1'b1};
      end else if (busy_r) begin
        if (!cnt_end) cnt_r <= cnt_r + 16'h0001;
        else if (tick) cnt_r <= 16'h0000;
        if (tick) begin
          q_r <= q_r + 2'h1;
          if (q_r == 2'h2) smp_r <= filt[1];
          if (q_r == 2'h3) begin
            sh_r  <= {sh_r[7:0], smp_r};
            bit_r <= bit_r + 4'h1;
            if (bit_r == last_bit) begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  // lines keep their last level between commands
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (busy_r) begin
      scl_oe_r <= !scl_rel;
      sda_oe_r <= !sda_rel;
    end
  end

  assign cmd_ready = !busy_r;
  assign done      = done_r;
  assign rx_byte   = sh_r[8:1];
  assign rx_ack    = sh_r[0];
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_oe_r;
  assign sda_oe    = sda_oe_r;

endmodule : sbsa_bit_engine

// >>> src/sbsa_pkg.sv
// package: register window, status bits and bus timing of the sbsa block
//------------------------------------------------------------------------
// Functional notes
// [R1] four byte registers in one dword
// [R2] data byte: transmit on write, receive on read
// [R3] word address sent on byte write/read
// [R4] quick protocol skips word address phase
// [R5] target register write launches transaction
// [R6] target register holds address and direction
// [R7] control byte: present, busy, error, controls
// [R8] software checks present and not busy first
// [R9] software loads word, then data for write
// [R10] software writes target register last
// [R11] busy set during operation, software polls
// [R12] software checks error after busy clears
// [R13] read byte lands in data register
// [R14] missing acknowledge sets error bit
// [R15] write: start, address, word, data, stop
// [R16] read: restart, address read, byte, nack, stop
// [R17] download busy shown throughout eeprom download
// [R18] direction in bit zero, one means read
// [R19] busy clears after stop; launches ignored while busy
//------------------------------------------------------------------------
package sbsa_pkg;

  //----------------------------------------------------------------------
  // register window
  //----------------------------------------------------------------------
  localparam logic [7:0] SBSA_DATA_OFS = 8'hB0;
  localparam logic [7:0] SBSA_WORD_OFS = 8'hB1;
  localparam logic [7:0] SBSA_TGT_OFS  = 8'hB2;
  localparam logic [7:0] SBSA_CTRL_OFS = 8'hB3;
  localparam logic [7:0] SBSA_REG_RST  = 8'h00;

  // control and status byte fields
  localparam int SBSA_CS_QUICK   = 7;
  localparam int SBSA_CS_REQUEST_BUSY_FLAG = 5;
  localparam int SBSA_CS_DLBUSY  = 4;
  localparam int SBSA_CS_DETECT  = 3;
  localparam int SBSA_CS_TEST    = 2;
  localparam int SBSA_CS_ERR     = 1;
  localparam int SBSA_CS_DLERR   = 0;

  // target register: direction in bit 0
  localparam int   SBSA_TGT_DIR  = 0;
  localparam logic SBSA_DIR_READ = 1'b1;

  //----------------------------------------------------------------------
  // bus timing
  //----------------------------------------------------------------------
  localparam int SBSA_CLK_HZ  = 125_000_000;
  localparam int SBSA_SCL_HZ  = 100_000;
  // quarter bit period, rounded up so the bus never runs too fast
  localparam int SBSA_QTR_CYC =
    (SBSA_CLK_HZ + 4 * SBSA_SCL_HZ - 1) / (4 * SBSA_SCL_HZ);

  typedef enum logic [1:0] {
    SBSA_CMD_START,
    SBSA_CMD_STOP,
    SBSA_CMD_WR,
    SBSA_CMD_RD
  } sbsa_cmd_t;

endpackage : sbsa_pkg

// >>> src/sbsa_top.sv
// sbsa_top: software single-byte access engine for the two-wire bus
module sbsa_top #(
  parameter int QTR_CYC = sbsa_pkg::SBSA_QTR_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // configuration access to the dword window
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  // eeprom loader status, same clock
  input  wire logic        download_busy_flag,
  input  wire logic        download_error,
  input  wire logic        interface_detected_flag,
  // test control out
  output logic             serial_test_control,
  // open-drain bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  import sbsa_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_SLA_W,
    ST_WORD,
    ST_DATA_W,
    ST_RSTART,
    ST_SLA_R,
    ST_DATA_R,
    ST_STOP
  } sbsa_state_t;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  //----------------------------------------------------------------------
  // decode helpers
  //----------------------------------------------------------------------
  function automatic logic lane_en(input logic [3:0] be,
                                   input logic [7:0] ofs);
    return be[ofs[1:0]];
  endfunction : lane_en

  function automatic logic [7:0] lane_byte(input logic [31:0] d,
                                           input logic [7:0]  ofs);
    return d[{ofs[1:0], 3'b000} +: 8];
  endfunction : lane_byte

  //----------------------------------------------------------------------
  // registers and wires
  //----------------------------------------------------------------------
  logic [7:0]  data_r, word_r, tgt_r;
  logic        quick_r, test_r, err_r, quick_run_r, pend_r;
  logic [31:0] rdata_r;
  logic        rvalid_r;
  sbsa_state_t state_r, state_nxt;
  logic        err_nxt;
  logic [7:0]  stat;

  logic        phy_ready, phy_done, phy_rx_ack;
  logic [7:0]  phy_rx, phy_tx;
  sbsa_cmd_t   phy_cmd;

  // [R1] dword window decode
  wire hit     = cfg_addr[7:2] == SBSA_DATA_OFS[7:2];
  wire busy    = state_r != ST_IDLE;
  wire wr_data = cfg_wr && hit && lane_en(cfg_be, SBSA_DATA_OFS);
  wire wr_word = cfg_wr && hit && lane_en(cfg_be, SBSA_WORD_OFS);
  wire wr_tgt  = cfg_wr && hit && lane_en(cfg_be, SBSA_TGT_OFS);
  wire wr_ctrl = cfg_wr && hit && lane_en(cfg_be, SBSA_CTRL_OFS);

  wire [7:0] wb_data = lane_byte(cfg_wdata, SBSA_DATA_OFS);
  wire [7:0] wb_word = lane_byte(cfg_wdata, SBSA_WORD_OFS);
  wire [7:0] wb_tgt  = lane_byte(cfg_wdata, SBSA_TGT_OFS);
  wire [7:0] wb_ctrl = lane_byte(cfg_wdata, SBSA_CTRL_OFS);

  // [R5] launch on target write
  wire launch  = wr_tgt && !busy;
  wire dir_rd  = tgt_r[SBSA_TGT_DIR] == SBSA_DIR_READ;
  wire ack_chk = state_r == ST_SLA_W || state_r == ST_WORD ||
                 state_r == ST_DATA_W || state_r == ST_SLA_R;
  // [R14] missing acknowledge
  wire err_set = phy_done && ack_chk && phy_rx_ack;
  wire err_clr = (wr_ctrl && wb_ctrl[SBSA_CS_ERR]) || launch;
  wire fire    = busy && !pend_r && phy_ready;

  //----------------------------------------------------------------------
  // software registers
  //----------------------------------------------------------------------
  // [R2] [R13] data byte store
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) data_r <= SBSA_REG_RST;
    else if (phy_done && state_r == ST_DATA_R) data_r <= phy_rx;
    else if (wr_data) data_r <= wb_data;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) word_r <= SBSA_REG_RST;
    else if (wr_word) word_r <= wb_word;
  end

  // [R19] target writes while busy ignored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) tgt_r <= SBSA_REG_RST;
    else if (launch) tgt_r <= wb_tgt;
  end

  // [R7] writable control bits
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      quick_r <= 1'b0;
      test_r  <= 1'b0;
    end else if (wr_ctrl) begin
      quick_r <= wb_ctrl[SBSA_CS_QUICK];
      test_r  <= wb_ctrl[SBSA_CS_TEST];
    end
  end

  // set wins over a same-cycle write-one clear
  assign err_nxt = err_set || (err_r && !err_clr);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) err_r <= 1'b0;
    else err_r <= err_nxt;
  end

  // protocol choice is frozen at launch so a late write cannot
  // reshape a transaction already on the wire
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) quick_run_r <= 1'b0;
    else if (launch) quick_run_r <= quick_r;
  end

  //----------------------------------------------------------------------
  // read path
  //----------------------------------------------------------------------
  // [R7] status byte assembly
  always_comb begin
    stat                  = 8'h00;
    stat[SBSA_CS_QUICK]   = quick_r;
    stat[SBSA_CS_REQUEST_BUSY_FLAG] = busy;
    // [R17] download busy shown
    stat[SBSA_CS_DLBUSY]  = download_busy_flag;
    stat[SBSA_CS_DETECT]  = interface_detected_flag;
    stat[SBSA_CS_TEST]    = test_r;
    stat[SBSA_CS_ERR]     = err_r;
    stat[SBSA_CS_DLERR]   = download_error;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cfg_rd;
      if (cfg_rd) rdata_r <= hit ? {stat, tgt_r, word_r, data_r}
                                 : 32'h0000_0000;
    end
  end

  assign cfg_rdata           = rdata_r;
  assign cfg_rvalid          = rvalid_r;
  assign serial_test_control = test_r;

  //----------------------------------------------------------------------
  // transaction sequencer
  //----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (launch) begin
      state_nxt = ST_START;
    end else if (phy_done) begin
      case (state_r)
        // [R4] quick path skips word
        ST_START:  state_nxt = (quick_run_r && dir_rd) ? ST_SLA_R
                                                       : ST_SLA_W;
        ST_SLA_W:  state_nxt = quick_run_r ? ST_DATA_W : ST_WORD;
        // [R16] restart before read
        ST_WORD:   state_nxt = dir_rd ? ST_RSTART : ST_DATA_W;
        ST_RSTART: state_nxt = ST_SLA_R;
        ST_SLA_R:  state_nxt = ST_DATA_R;
        ST_DATA_W: state_nxt = ST_STOP;
        ST_DATA_R: state_nxt = ST_STOP;
        // [R11] busy ends after stop
        ST_STOP:   state_nxt = ST_IDLE;
        default:   state_nxt = state_r;
      endcase
      if (err_set) state_nxt = ST_STOP;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) pend_r <= 1'b0;
    else if (fire) pend_r <= 1'b1;
    else if (phy_done) pend_r <= 1'b0;
  end

  // [R15] command per phase
  assign phy_cmd = (state_r == ST_START || state_r == ST_RSTART)
                   ? SBSA_CMD_START
                   : (state_r == ST_STOP)   ? SBSA_CMD_STOP
                   : (state_r == ST_DATA_R) ? SBSA_CMD_RD
                   : SBSA_CMD_WR;

  // [R3] [R6] [R18] byte per phase
  assign phy_tx = (state_r == ST_SLA_W) ? {tgt_r[7:1], !SBSA_DIR_READ}
                : (state_r == ST_SLA_R) ? {tgt_r[7:1], SBSA_DIR_READ}
                : (state_r == ST_WORD)  ? word_r
                : data_r;

  sbsa_bit_engine #(
    .QTR_CYC (QTR_CYC)
  ) u_engine (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .cmd_valid (busy && !pend_r),
    .cmd_ready (phy_ready),
    .cmd       (phy_cmd),
    .tx_byte   (phy_tx),
    // single byte read always ends with no acknowledge
    .tx_ack    (1'b1),
    .done      (phy_done),
    .rx_byte   (phy_rx),
    .rx_ack    (phy_rx_ack),
    .scl_i     (scl_i),
    .scl_o     (scl_o),
    .scl_oe    (scl_oe),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe    (sda_oe)
  );

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------
  sequence s_nack;
    phy_done && ack_chk && phy_rx_ack;
  endsequence

  sequence s_read_byte;
    state_r == ST_DATA_R && phy_done;
  endsequence

  // [R5] launch starts transaction
  a_launch_start: // [R5]
    assert property (launch |=> busy && state_r == ST_START)
    else $error("target write did not launch");

  // [R19] busy ignores launch
  a_busy_ignore: // [R19]
    assert property (wr_tgt && busy |=> tgt_r == $past(tgt_r))
    else $error("target changed while busy");

  // [R14] nack sets error
  a_nack_err: // [R14]
    assert property (s_nack |=> err_r && state_r == ST_STOP)
    else $error("nack did not set error");

  // [R4] quick skips word
  a_quick_skip: // [R4]
    assert property (state_r == ST_SLA_W && phy_done && !phy_rx_ack &&
                     quick_run_r |=> state_r == ST_DATA_W)
    else $error("quick write entered word phase");

  // [R3] word byte sent
  a_word_sent: // [R3]
    assert property (fire && state_r == ST_WORD |->
                     phy_tx == word_r && !quick_run_r &&
                     phy_cmd == SBSA_CMD_WR)
    else $error("word phase sent wrong byte");

  // [R13] read byte captured
  a_read_capture: // [R13]
    assert property (s_read_byte |=>
                     data_r == $past(phy_rx) && state_r == ST_STOP)
    else $error("read byte not captured");

  // [R11] busy drops after stop
  a_stop_last: // [R11]
    assert property ($fell(busy) |->
                     $past(state_r) == ST_STOP && $past(phy_done))
    else $error("busy cleared before stop");

  // [R16] read address phase
  a_read_dir: // [R16]
    assert property (fire && state_r == ST_SLA_R |->
                     phy_tx[SBSA_TGT_DIR] == SBSA_DIR_READ ##1 pend_r)
    else $error("read address without read bit");

  // [R17] download busy visible
  a_dl_busy: // [R17]
    assert property (cfg_rd && hit && download_busy_flag |=>
                     cfg_rvalid && cfg_rdata[24 + SBSA_CS_DLBUSY])
    else $error("download busy not reported");

  // [R7] request busy visible
  a_req_busy: // [R7]
    assert property (cfg_rd && hit |=>
                     cfg_rdata[24 + SBSA_CS_REQUEST_BUSY_FLAG] == $past(busy))
    else $error("request busy misreported");

endmodule : sbsa_top
